// File: dv/nvsrs_host.sv
`timescale 1ns/10ps
`default_nettype none
// host side model: one request at a time, every change on the falling edge
module nvsrs_host (
    input  wire logic       CLK,
    input  wire logic       ACCESS_OK,
    output logic            CS_N,
    output logic            WRITE_STB,
    output logic            CMD_STB,
    output logic [2:0]      CMD
);
    // chip selected from the start so standby only comes when asked for
    initial begin
        CS_N      = 1'b0;
        WRITE_STB = 1'b0;
        CMD_STB   = 1'b0;
        CMD       = 3'h0;
    end

    // a host never presses a busy part; bounded so a dead part cannot hang it
    task automatic wait_ready();
        int n;
        n = 0;
        while (ACCESS_OK !== 1'b1 && n < 20000) begin
            @(negedge CLK);
            n++;
        end
    endtask

    // polite=0 lets the bench aim a write at a locked device
    task automatic write_one(input bit polite);
        if (polite)
            wait_ready();
        @(negedge CLK);
        WRITE_STB = 1'b1;
        @(negedge CLK);
        WRITE_STB = 1'b0;
    endtask

    // code lines flip once released; the flipped code is itself a valid command for codes 2 to 5
    task automatic send_cmd(input logic [2:0] code);
        wait_ready();
        @(negedge CLK);
        CMD     = code;
        CMD_STB = 1'b1;
        @(negedge CLK);
        CMD_STB = 1'b0;
        CMD     = ~code;
    endtask

    task automatic set_cs(input logic v);
        @(negedge CLK);
        CS_N = v;
    endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // short counts keep the run brief; bounds below follow them
    localparam int BOOT_N  = 40;
    localparam int SAVE_N  = 60;
    localparam int SLEEP_N = 30;
    localparam int WAKE_N  = 50;
    localparam int A_OK = 6, SAV = 5, RST = 4, SLP = 3, SBY = 2, AEN = 1;

    logic                   clk;
    logic                   reset;
    logic                   supply_ok;
    logic                   cs_n;
    logic                   write_stb;
    logic                   cmd_stb;
    logic [2:0]             cmd;
    nvsrs_pkg::nvsrs_stat_t st;
    int                     n_mismatch;
    int                     samples_checked;

    nvsrs_seq #(.BOOT_CYC(BOOT_N), .SAVE_CYC(SAVE_N), .SLEEP_CYC(SLEEP_N), .WAKE_CYC(WAKE_N)) dut (
        .CLK(clk), .RESET(reset), .SUPPLY_OK(supply_ok), .CS_N(cs_n),
        .WRITE_STB(write_stb), .CMD_STB(cmd_stb), .CMD(cmd),
        .ACCESS_OK(st.access_ok), .SAVING(st.saving), .RESTORING(st.restoring),
        .ASLEEP(st.asleep), .STANDBY(st.standby), .AUTO_EN(st.auto_en), .DIRTY(st.dirty)
    );

    nvsrs_host host (
        .CLK(clk), .ACCESS_OK(st.access_ok), .CS_N(cs_n),
        .WRITE_STB(write_stb), .CMD_STB(cmd_stb), .CMD(cmd)
    );

    always #25 clk = ~clk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // bounded wait on one status bit, then judged against the wanted level
    task automatic wait_bit(input string what, input int idx, input logic val, input int lim);
        int n;
        n = 0;
        while (st[idx] !== val && n < lim) begin
            @(negedge clk);
            n++;
        end
        check(what, {31'h0, st[idx]}, {31'h0, val});
    endtask

    // a write during the boot restore must leave nothing behind
    task automatic t_boot();
        supply_ok = 1'b1;
        host.write_one(1'b0);
        check("restoring", st.restoring, 1'b1);
        wait_bit("boot done", A_OK, 1'b1, BOOT_N + 4);
        check("dirty after boot", st.dirty, 1'b0);
        $display("test boot done");
    endtask

    task automatic t_save();
        host.write_one(1'b1);
        @(negedge clk);
        check("dirty", st.dirty, 1'b1);
        host.send_cmd(nvsrs_pkg::NVSRS_CMD_SAVE);
        wait_bit("save lock", A_OK, 1'b0, 4);
        wait_bit("save start", SAV, 1'b1, nvsrs_pkg::SOFT_SEQ_CYC);
        host.write_one(1'b0);
        wait_bit("save end", SAV, 1'b0, SAVE_N + 4);
        check("access after save", st.access_ok, 1'b1);
        check("dirty after save", st.dirty, 1'b0);
        $display("test save done");
    endtask

    task automatic t_restore();
        host.write_one(1'b1);
        host.send_cmd(nvsrs_pkg::NVSRS_CMD_RESTORE);
        wait_bit("restore start", RST, 1'b1, nvsrs_pkg::SOFT_SEQ_CYC);
        check("restore lock", st.access_ok, 1'b0);
        wait_bit("restore end", A_OK, 1'b1, nvsrs_pkg::RESTORE_SW_CYC + 4);
        check("restoring", st.restoring, 1'b0);
        check("dirty after restore", st.dirty, 1'b0);
        $display("test restore done");
    endtask

    // enable, an unknown code, then disable
    task automatic t_modes();
        host.send_cmd(nvsrs_pkg::NVSRS_CMD_AUTO_EN);
        wait_bit("auto on", AEN, 1'b1, 8);
        host.send_cmd(3'h7);
        repeat (6) @(negedge clk);
        check("unknown code", {st.access_ok, st.auto_en, st.saving}, 3'h6);
        host.send_cmd(nvsrs_pkg::NVSRS_CMD_AUTO_DIS);
        wait_bit("auto off", AEN, 1'b0, 8);
        wait_bit("grace over", A_OK, 1'b1, 8);
        $display("test modes done");
    endtask

    task automatic t_standby();
        host.set_cs(1'b1);
        wait_bit("standby", SBY, 1'b1, nvsrs_pkg::STANDBY_ENTRY_CYC + 4);
        host.set_cs(1'b0);
        @(negedge clk);
        check("standby left", st.standby, 1'b0);
        $display("test standby done");
    endtask

    // wake is triggered by chip select falling while asleep
    task automatic t_sleep();
        host.send_cmd(nvsrs_pkg::NVSRS_CMD_SLEEP);
        host.set_cs(1'b1);
        wait_bit("asleep", SLP, 1'b1, SLEEP_N + 8);
        check("sleep lock", st.access_ok, 1'b0);
        host.set_cs(1'b0);
        wait_bit("awake", A_OK, 1'b1, WAKE_N + 4);
        check("asleep after wake", st.asleep, 1'b0);
        $display("test sleep done");
    endtask

    // written data with auto save on: supply loss must save, then reboot
    task automatic t_power_loss();
        host.send_cmd(nvsrs_pkg::NVSRS_CMD_AUTO_EN);
        host.write_one(1'b1);
        @(negedge clk);
        supply_ok = 1'b0;
        wait_bit("auto save", SAV, 1'b1, 4);
        check("low supply lock", st.access_ok, 1'b0);
        wait_bit("auto save end", SAV, 1'b0, SAVE_N + 4);
        supply_ok = 1'b1;
        wait_bit("reboot", A_OK, 1'b1, BOOT_N + 4);
        $display("test power loss done");
    endtask

    // reset in mid-run: all status low, then a fresh boot restore with auto save off
    task automatic t_reset();
        reset = 1'b1;
        repeat (2) @(negedge clk);
        check("outputs in reset", st, nvsrs_pkg::STAT_RST);
        reset = 1'b0;
        @(negedge clk);
        check("restore after reset", {st.restoring, st.access_ok}, 2'h2);
        wait_bit("boot after reset", A_OK, 1'b1, BOOT_N + 4);
        check("auto after reset", st.auto_en, 1'b0);
        $display("test reset done");
    endtask

    // nothing written since the boot restore: no save on supply loss
    task automatic t_skip();
        host.send_cmd(nvsrs_pkg::NVSRS_CMD_AUTO_EN);
        wait_bit("auto on again", AEN, 1'b1, 8);
        supply_ok = 1'b0;
        repeat (6) @(negedge clk);
        check("skip save", {st.saving, st.access_ok}, 2'h0);
        $display("test skip done");
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        clk             = 1'b0;
        reset           = 1'b1;
        supply_ok       = 1'b0;
        n_mismatch      = 0;
        samples_checked = 0;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        t_boot();
        t_save();
        t_restore();
        t_modes();
        t_standby();
        t_sleep();
        t_power_loss();
        t_reset();
        t_skip();
        results();
    end

    // all tests need about 15000 cycles; a hang is cut well after that
    initial begin
        #(40_000 * 50);
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire

// File: pkg/nvsrs_pkg.sv
package nvsrs_pkg;

    // clock rate used to turn times into cycle counts
    localparam int CLK_HZ = 20_000_000;

    // times as printed, in their own units
    localparam int BOOT_RESTORE_MS    = 20;
    localparam int SAVE_MAX_MS        = 8;
    localparam int WRITE_GRACE_NS     = 25;
    localparam int SLEEP_ENTRY_MS     = 8;
    localparam int WAKE_MS            = 20;
    localparam int STANDBY_ENTRY_US   = 100;
    localparam int SOFT_SEQ_US        = 500;
    localparam int RESTORE_SW_US      = 600;

    // the write grace rounds down, never below one cycle
    localparam int BOOT_RESTORE_CYC  = BOOT_RESTORE_MS * (CLK_HZ / 1000);
    localparam int SAVE_CYC          = SAVE_MAX_MS * (CLK_HZ / 1000);
    localparam int GRACE_RAW         = (WRITE_GRACE_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int WRITE_GRACE_CYC   = (GRACE_RAW < 1) ? 1 : GRACE_RAW;
    localparam int SLEEP_ENTRY_CYC   = SLEEP_ENTRY_MS * (CLK_HZ / 1000);
    localparam int WAKE_CYC          = WAKE_MS * (CLK_HZ / 1000);
    localparam int STANDBY_ENTRY_CYC = STANDBY_ENTRY_US * (CLK_HZ / 1_000_000);
    localparam int SOFT_SEQ_CYC      = SOFT_SEQ_US * (CLK_HZ / 1_000_000);
    localparam int RESTORE_SW_CYC    = RESTORE_SW_US * (CLK_HZ / 1_000_000);

    localparam int CNT_W = 20;

    // command codes on the command strobe
    typedef enum logic [2:0] {
        NVSRS_CMD_SAVE     = 3'h1,
        NVSRS_CMD_RESTORE  = 3'h2,
        NVSRS_CMD_AUTO_EN  = 3'h3,
        NVSRS_CMD_AUTO_DIS = 3'h4,
        NVSRS_CMD_SLEEP    = 3'h5
    } nvsrs_cmd_t;

    typedef enum logic [7:0] {
        NVSRS_ST_BOOT    = 8'h01,
        NVSRS_ST_ACTIVE  = 8'h02,
        NVSRS_ST_GRACE   = 8'h04,
        NVSRS_ST_SAVE    = 8'h08,
        NVSRS_ST_RESTORE = 8'h10,
        NVSRS_ST_SLEEP   = 8'h20,
        NVSRS_ST_WAKE    = 8'h40,
        NVSRS_ST_OFF     = 8'h80
    } nvsrs_state_t;

    // status bundle leaving the block
    typedef struct packed {
        logic access_ok;
        logic saving;
        logic restoring;
        logic asleep;
        logic standby;
        logic auto_en;
        logic dirty;
    } nvsrs_stat_t;

    localparam nvsrs_stat_t STAT_RST = 7'h00;

endpackage

// File: src/nvsrs_seq.sv
`timescale 1ns/10ps
`default_nettype none
module nvsrs_seq #(
    parameter int BOOT_CYC  = nvsrs_pkg::BOOT_RESTORE_CYC,
    parameter int SAVE_CYC  = nvsrs_pkg::SAVE_CYC,
    parameter int SLEEP_CYC = nvsrs_pkg::SLEEP_ENTRY_CYC,
    parameter int WAKE_CYC  = nvsrs_pkg::WAKE_CYC
) (
    input  wire logic                   CLK,
    input  wire logic                   RESET,
    input  wire logic                   SUPPLY_OK,
    input  wire logic                   CS_N,
    input  wire logic                   WRITE_STB,
    input  wire logic                   CMD_STB,
    input  wire logic [2:0]             CMD,
    output logic                        ACCESS_OK,
    output logic                        SAVING,
    output logic                        RESTORING,
    output logic                        ASLEEP,
    output logic                        STANDBY,
    output logic                        AUTO_EN,
    output logic                        DIRTY
);
    typedef struct packed {
        nvsrs_pkg::nvsrs_state_t     st;
        nvsrs_pkg::nvsrs_cmd_t       pend;
        logic [nvsrs_pkg::CNT_W-1:0] sb_cnt;
        logic                        cs_q;
        logic                        sup_q;
        nvsrs_pkg::nvsrs_stat_t      stat;
    } nvsrs_core_t;

    nvsrs_core_t core_ff;
    nvsrs_core_t nxt_core;
    logic                        tmr_load;
    logic [nvsrs_pkg::CNT_W-1:0] tmr_val;
    logic                        tmr_done;

    // state that lets the host through
    function automatic logic open_state(nvsrs_pkg::nvsrs_state_t s);
        return (s == nvsrs_pkg::NVSRS_ST_ACTIVE) || (s == nvsrs_pkg::NVSRS_ST_GRACE);
    endfunction

    nvsrs_timer u_tmr (
        .CLK   (CLK),
        .RESET (RESET),
        .load  (tmr_load),
        .value (tmr_val),
        .done  (tmr_done)
    );

    // main sequencer; one shared timer suffices since phases never overlap
    always_comb begin
        nxt_core = core_ff;
        tmr_load = 1'b0;
        tmr_val  = '0;
        nxt_core.cs_q  = CS_N;
        nxt_core.sup_q = SUPPLY_OK;
        // dirty set by writes only while access is open; clear wins over set
        if (WRITE_STB && core_ff.stat.access_ok) begin
            nxt_core.stat.dirty = 1'b1;
        end
        case (core_ff.st)
            nvsrs_pkg::NVSRS_ST_OFF: begin
                if (SUPPLY_OK) begin
                    nxt_core.st = nvsrs_pkg::NVSRS_ST_BOOT;
                    tmr_load    = 1'b1;
                    tmr_val     = BOOT_CYC[nvsrs_pkg::CNT_W-1:0];
                end
            end
            nvsrs_pkg::NVSRS_ST_BOOT: begin
                if (tmr_done) begin
                    nxt_core.st         = nvsrs_pkg::NVSRS_ST_ACTIVE;
                    nxt_core.stat.dirty = 1'b0;
                end
            end
            nvsrs_pkg::NVSRS_ST_ACTIVE: begin
                if (CMD_STB) begin
                    // grace window lets a write in flight finish
                    nxt_core.pend = nvsrs_pkg::nvsrs_cmd_t'(CMD);
                    nxt_core.st   = nvsrs_pkg::NVSRS_ST_GRACE;
                    tmr_load      = 1'b1;
                    tmr_val       = nvsrs_pkg::WRITE_GRACE_CYC[nvsrs_pkg::CNT_W-1:0];
                end
            end
            nvsrs_pkg::NVSRS_ST_GRACE: begin
                if (tmr_done) begin
                    nxt_core.st = nvsrs_pkg::NVSRS_ST_ACTIVE;
                    if (core_ff.pend == nvsrs_pkg::NVSRS_CMD_SAVE) begin
                        nxt_core.st = nvsrs_pkg::NVSRS_ST_SAVE;
                        tmr_load    = 1'b1;
                        tmr_val     = SAVE_CYC[nvsrs_pkg::CNT_W-1:0];
                    end else if (core_ff.pend == nvsrs_pkg::NVSRS_CMD_RESTORE) begin
                        nxt_core.st = nvsrs_pkg::NVSRS_ST_RESTORE;
                        tmr_load    = 1'b1;
                        tmr_val     = nvsrs_pkg::RESTORE_SW_CYC[nvsrs_pkg::CNT_W-1:0];
                    end else if (core_ff.pend == nvsrs_pkg::NVSRS_CMD_SLEEP) begin
                        nxt_core.st = nvsrs_pkg::NVSRS_ST_SLEEP;
                        tmr_load    = 1'b1;
                        tmr_val     = SLEEP_CYC[nvsrs_pkg::CNT_W-1:0];
                    end else if (core_ff.pend == nvsrs_pkg::NVSRS_CMD_AUTO_EN) begin
                        nxt_core.stat.auto_en = 1'b1;
                    end else if (core_ff.pend == nvsrs_pkg::NVSRS_CMD_AUTO_DIS) begin
                        nxt_core.stat.auto_en = 1'b0;
                    end
                end
            end
            nvsrs_pkg::NVSRS_ST_SAVE, nvsrs_pkg::NVSRS_ST_RESTORE: begin
                if (tmr_done) begin
                    nxt_core.st         = nvsrs_pkg::NVSRS_ST_ACTIVE;
                    nxt_core.stat.dirty = 1'b0;
                end
            end
            nvsrs_pkg::NVSRS_ST_SLEEP: begin
                // sleep entry takes the full window; wake on chip select fall
                if (!core_ff.stat.asleep && tmr_done) begin
                    nxt_core.stat.asleep = 1'b1;
                end else if (core_ff.stat.asleep && core_ff.cs_q && !CS_N) begin
                    nxt_core.st          = nvsrs_pkg::NVSRS_ST_WAKE;
                    nxt_core.stat.asleep = 1'b0;
                    tmr_load             = 1'b1;
                    tmr_val              = WAKE_CYC[nvsrs_pkg::CNT_W-1:0];
                end
            end
            nvsrs_pkg::NVSRS_ST_WAKE: begin
                if (tmr_done) begin
                    nxt_core.st = nvsrs_pkg::NVSRS_ST_ACTIVE;
                end
            end
            default: begin
                nxt_core.st = nvsrs_pkg::NVSRS_ST_OFF;
            end
        endcase
        // supply loss overrides all; save only if something changed
        if (!SUPPLY_OK && core_ff.st != nvsrs_pkg::NVSRS_ST_OFF) begin
            nxt_core.stat.asleep = 1'b0;
            if (core_ff.sup_q && core_ff.stat.auto_en && core_ff.stat.dirty) begin
                nxt_core.st = nvsrs_pkg::NVSRS_ST_SAVE;
                tmr_load    = 1'b1;
                tmr_val     = SAVE_CYC[nvsrs_pkg::CNT_W-1:0];
            end else if (core_ff.st != nvsrs_pkg::NVSRS_ST_SAVE) begin
                nxt_core.st = nvsrs_pkg::NVSRS_ST_OFF;
            end else if (tmr_done) begin
                nxt_core.st         = nvsrs_pkg::NVSRS_ST_OFF;
                nxt_core.stat.dirty = 1'b0;
            end
        end
        // standby count starts when chip select rises, idle only
        if (!CS_N && core_ff.st == nvsrs_pkg::NVSRS_ST_ACTIVE) begin
            nxt_core.sb_cnt       = '0;
            nxt_core.stat.standby = 1'b0;
        end else if (CS_N && core_ff.st == nvsrs_pkg::NVSRS_ST_ACTIVE) begin
            if (core_ff.sb_cnt >= nvsrs_pkg::STANDBY_ENTRY_CYC[nvsrs_pkg::CNT_W-1:0] - 20'h00001)
            begin
                nxt_core.stat.standby = 1'b1;
            end else begin
                nxt_core.sb_cnt = core_ff.sb_cnt + 20'h00001;
            end
        end else begin
            nxt_core.sb_cnt       = '0;
            nxt_core.stat.standby = 1'b0;
        end
        nxt_core.stat.access_ok = open_state(nxt_core.st) && SUPPLY_OK;
        nxt_core.stat.saving    = (nxt_core.st == nvsrs_pkg::NVSRS_ST_SAVE);
        nxt_core.stat.restoring = (nxt_core.st == nvsrs_pkg::NVSRS_ST_RESTORE)
                                || (nxt_core.st == nvsrs_pkg::NVSRS_ST_BOOT);
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            core_ff.st     <= nvsrs_pkg::NVSRS_ST_OFF;
            core_ff.pend   <= nvsrs_pkg::NVSRS_CMD_SAVE;
            core_ff.sb_cnt <= '0;
            core_ff.cs_q   <= 1'b1;
            core_ff.sup_q  <= 1'b0;
            core_ff.stat   <= nvsrs_pkg::STAT_RST;
        end else begin
            core_ff <= nxt_core;
        end
    end

    assign ACCESS_OK = core_ff.stat.access_ok;
    assign SAVING    = core_ff.stat.saving;
    assign RESTORING = core_ff.stat.restoring;
    assign ASLEEP    = core_ff.stat.asleep;
    assign STANDBY   = core_ff.stat.standby;
    assign AUTO_EN   = core_ff.stat.auto_en;
    assign DIRTY     = core_ff.stat.dirty;

    // access never open while an operation runs
    chk_no_access_busy: assert property (@(posedge CLK) disable iff (RESET)
        (SAVING || RESTORING) |-> !ACCESS_OK)
        else $error("access open during save or restore");

    chk_grace_ends: assert property (@(posedge CLK) disable iff (RESET)
        (core_ff.st == nvsrs_pkg::NVSRS_ST_ACTIVE && CMD_STB && SUPPLY_OK)
        |=> ##[1:3] core_ff.st != nvsrs_pkg::NVSRS_ST_GRACE)
        else $error("grace window too long");

    chk_save_skip: assert property (@(posedge CLK) disable iff (RESET)
        (core_ff.st == nvsrs_pkg::NVSRS_ST_ACTIVE && !DIRTY && !SUPPLY_OK) |=> !SAVING)
        else $error("clean power loss started a save");

    chk_standby_time: assert property (@(posedge CLK) disable iff (RESET)
        (core_ff.sb_cnt == 20'h00000) |-> !STANDBY)
        else $error("standby without idle count");

    // a full idle count with chip select high must raise standby at the next edge
    chk_standby_entry: assert property (@(posedge CLK) disable iff (RESET)
        (CS_N && core_ff.st == nvsrs_pkg::NVSRS_ST_ACTIVE
            && core_ff.sb_cnt >= nvsrs_pkg::STANDBY_ENTRY_CYC - 1) |=> STANDBY)
        else $error("standby entry late");

    chk_supply_low: assert property (@(posedge CLK) disable iff (RESET)
        !SUPPLY_OK |=> !ACCESS_OK)
        else $error("access open on low supply");

    chk_restore_busy: assert property (@(posedge CLK) disable iff (RESET)
        $rose(core_ff.st == nvsrs_pkg::NVSRS_ST_RESTORE) |-> RESTORING && !ACCESS_OK)
        else $error("restore not blocking");

    chk_save_clears: assert property (@(posedge CLK) disable iff (RESET)
        ($fell(SAVING) && SUPPLY_OK && !$past(WRITE_STB)) |-> !DIRTY)
        else $error("dirty left after save");

    chk_wake_block: assert property (@(posedge CLK) disable iff (RESET)
        (core_ff.st == nvsrs_pkg::NVSRS_ST_WAKE) |-> !ACCESS_OK)
        else $error("service during wake");

    chk_boot_block: assert property (@(posedge CLK) disable iff (RESET)
        (core_ff.st == nvsrs_pkg::NVSRS_ST_BOOT) |-> RESTORING)
        else $error("boot restore not flagged");
endmodule
`default_nettype wire

// File: src/nvsrs_timer.sv
`timescale 1ns/10ps
`default_nettype none
// down counter, done pulses for one cycle when the count runs out
module nvsrs_timer (
    input  wire logic                       CLK,
    input  wire logic                       RESET,
    input  wire logic                       load,
    input  wire logic [nvsrs_pkg::CNT_W-1:0] value,
    output logic                            done
);
    typedef struct packed {
        logic [nvsrs_pkg::CNT_W-1:0] cnt;
        logic                        run;
        logic                        done;
    } nvsrs_tmr_t;

    nvsrs_tmr_t tmr_ff;
    nvsrs_tmr_t nxt_tmr;

    // reload wins over a running count
    always_comb begin
        nxt_tmr      = tmr_ff;
        nxt_tmr.done = 1'b0;
        if (load) begin
            nxt_tmr.cnt = value;
            nxt_tmr.run = 1'b1;
        end else if (tmr_ff.run) begin
            if (tmr_ff.cnt <= 20'h00001) begin
                nxt_tmr.run  = 1'b0;
                nxt_tmr.done = 1'b1;
            end else begin
                nxt_tmr.cnt = tmr_ff.cnt - 20'h00001;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tmr_ff <= '0;
        end else begin
            tmr_ff <= nxt_tmr;
        end
    end

    assign done = tmr_ff.done;
endmodule
`default_nettype wire
